/* rtl/i2c_register_access_slave.sv */
// register slave end of the two-wire control port, with its register store
// assumes scl/sda come asynchronously from the link and the strap from a pin
//
// How it works
// - works at 100 kHz and 400 kHz
// - slave only, never holds the clock
// - bytes MSB first, ninth clock acknowledges
// - start and stop seen while clock high
// - acknowledge holds data low whole clock
// - strap picks address 0011010 or 0011011
// - master writes key to register 0xF8
// - then 0xF9 sets the new address
// - low subaddresses bytewise, high ones four-byte words
// - reads continue while master acknowledges
// - unused bits of narrow registers read zero
// - incomplete register data discarded at stop/start
// - sequential writes fill following subaddresses
// - acknowledge address, subaddress and data bytes
// - read: subaddress write, repeated start, read
// - master acknowledges all but last byte
// - master ends read with nack, stop
// - no limit on bytes per transaction
//
// Our own choice: register access through a core read port and commit outputs.
`timescale 1ns/1ps
`default_nettype none
module i2c_register_access_slave (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic        addr_sel_i,
  input  wire logic [7:0]  core_rd_addr_i,
  i2c_link_if.device       link,
  output logic      [31:0] core_rd_data_o,
  output logic             commit_o,
  output logic      [7:0]  commit_addr_o,
  output logic      [31:0] commit_data_o,
  output logic      [6:0]  slave_addr_o
);

  logic [31:0] mem [0:255];

  logic                    scl_meta_reg;
  logic                    scl_sync_reg;
  logic                    scl_prev_reg;
  logic                    sda_meta_reg;
  logic                    sda_sync_reg;
  logic                    sda_prev_reg;
  logic                    strap_meta_reg;
  logic                    strap_sync_reg;
  logic [1:0]              strap_cnt_reg;
  i2c_link_pkg::dev_state_e state_reg;
  logic [3:0]              bit_cnt_reg;
  logic [7:0]              shift_reg;
  logic [7:0]              tx_reg;
  logic [7:0]              sub_reg;
  logic [1:0]              byte_idx_reg;
  logic [31:0]             word_reg;
  logic                    sda_low_reg;
  logic                    key_armed_reg;
  logic [6:0]              addr_reg;

  // line events from the synchronised samples
  wire scl_rise  = scl_sync_reg & ~scl_prev_reg;
  wire scl_fall  = ~scl_sync_reg & scl_prev_reg;
  wire start_det = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg;
  wire stop_det  = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg;
  wire active    = (state_reg != i2c_link_pkg::ST_IDLE) && (state_reg != i2c_link_pkg::ST_IGNORE);
  wire at_ack    = (bit_cnt_reg == i2c_link_pkg::ACK_BIT);
  wire at_last   = (bit_cnt_reg == i2c_link_pkg::LAST_DATA_BIT);
  wire byte_done = active & scl_fall & at_last;

  wire addr_match  = (shift_reg[7:1] == addr_reg);
  wire sub_is_word = (sub_reg >= i2c_link_pkg::SUB_WORD_BASE);
  wire last_byte   = ~sub_is_word | (byte_idx_reg == i2c_link_pkg::LAST_BYTE_IDX);
  wire [31:0] wr_word = {word_reg[23:0], shift_reg};
  // a register is committed only once its last byte has arrived
  wire wr_complete = byte_done & (state_reg == i2c_link_pkg::ST_WR) & last_byte;
  wire [31:0] commit_word = sub_is_word ? wr_word : {24'h000000, shift_reg};

  wire [31:0] rd_word    = mem[sub_reg];
  wire [31:0] rd_shifted = rd_word >> {~byte_idx_reg, 3'b000};
  wire [7:0]  rd_byte    = sub_is_word ? rd_shifted[7:0] : rd_word[7:0];

  // never stretches the clock: only data is ever driven, and only low
  assign link.dev_sda_o   = 1'b0;
  assign link.dev_sda_oen = ~sda_low_reg;
  assign slave_addr_o     = addr_reg;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_meta_reg   <= 1'b1;
      scl_sync_reg   <= 1'b1;
      scl_prev_reg   <= 1'b1;
      sda_meta_reg   <= 1'b1;
      sda_sync_reg   <= 1'b1;
      sda_prev_reg   <= 1'b1;
      strap_meta_reg <= 1'b0;
      strap_sync_reg <= 1'b0;
    end else if (ce_i) begin
      scl_meta_reg   <= link.scl;
      scl_sync_reg   <= scl_meta_reg;
      scl_prev_reg   <= scl_sync_reg;
      sda_meta_reg   <= link.sda;
      sda_sync_reg   <= sda_meta_reg;
      sda_prev_reg   <= sda_sync_reg;
      strap_meta_reg <= addr_sel_i;
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // slave address: strap caught after release, then key-guarded change
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_cnt_reg <= 2'h0;
      addr_reg      <= i2c_link_pkg::ADDR_STRAP_LOW;
      key_armed_reg <= 1'b0;
    end else if (ce_i) begin
      if (strap_cnt_reg != 2'h3) begin
        strap_cnt_reg <= strap_cnt_reg + 2'h1;
      end
      if (strap_cnt_reg == 2'h2) begin
        addr_reg <= strap_sync_reg ? i2c_link_pkg::ADDR_STRAP_HIGH : i2c_link_pkg::ADDR_STRAP_LOW;
      end else if (wr_complete && sub_reg == i2c_link_pkg::SUB_KEY) begin
        key_armed_reg <= (wr_word == i2c_link_pkg::KEY_VALUE);
      end else if (wr_complete && sub_reg == i2c_link_pkg::SUB_NEW_ADDR) begin
        if (key_armed_reg) begin
          addr_reg <= wr_word[7:1];
        end
        key_armed_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg    <= i2c_link_pkg::ST_IDLE;
      bit_cnt_reg  <= 4'h0;
      shift_reg    <= 8'h00;
      tx_reg       <= 8'h00;
      sub_reg      <= 8'h00;
      byte_idx_reg <= 2'h0;
      word_reg     <= 32'h00000000;
      sda_low_reg  <= 1'b0;
    end else if (ce_i) begin
      if (stop_det) begin
        state_reg   <= i2c_link_pkg::ST_IDLE;
        bit_cnt_reg <= 4'h0;
        sda_low_reg <= 1'b0;
      end else if (start_det) begin
        // repeated start drops any partial register
        state_reg    <= i2c_link_pkg::ST_ADDR;
        // the clock fall that ends the start wraps this to zero
        bit_cnt_reg  <= 4'hF;
        byte_idx_reg <= 2'h0;
        sda_low_reg  <= 1'b0;
      end else if (active && scl_rise) begin
        if (!bit_cnt_reg[3]) begin
          shift_reg <= {shift_reg[6:0], sda_sync_reg};
        end else if (state_reg == i2c_link_pkg::ST_RD && sda_sync_reg) begin
          state_reg <= i2c_link_pkg::ST_IGNORE;
        end
      end else if (active && scl_fall) begin
        if (at_ack) begin
          bit_cnt_reg <= 4'h0;
          if (state_reg == i2c_link_pkg::ST_RD) begin
            // master acknowledged (or address acked): send next byte
            tx_reg      <= {rd_byte[6:0], 1'b0};
            sda_low_reg <= ~rd_byte[7];
            if (last_byte) begin
              sub_reg      <= sub_reg + 8'h01;
              byte_idx_reg <= 2'h0;
            end else begin
              byte_idx_reg <= byte_idx_reg + 2'h1;
            end
          end else begin
            sda_low_reg <= 1'b0;
          end
        end else begin
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
          if (state_reg == i2c_link_pkg::ST_RD) begin
            if (at_last) begin
              sda_low_reg <= 1'b0;
            end else begin
              sda_low_reg <= ~tx_reg[7];
              tx_reg      <= {tx_reg[6:0], 1'b0};
            end
          end else if (at_last) begin
            case (state_reg)
              i2c_link_pkg::ST_ADDR: begin
                if (addr_match) begin
                  sda_low_reg  <= 1'b1;
                  byte_idx_reg <= 2'h0;
                  state_reg    <= shift_reg[0] ? i2c_link_pkg::ST_RD : i2c_link_pkg::ST_SUB;
                end else begin
                  state_reg <= i2c_link_pkg::ST_IGNORE;
                end
              end
              i2c_link_pkg::ST_SUB: begin
                sub_reg      <= shift_reg;
                byte_idx_reg <= 2'h0;
                sda_low_reg  <= 1'b1;
                state_reg    <= i2c_link_pkg::ST_WR;
              end
              i2c_link_pkg::ST_WR: begin
                // no byte limit: the subaddress simply keeps advancing
                sda_low_reg <= 1'b1;
                word_reg    <= wr_word;
                if (last_byte) begin
                  sub_reg      <= sub_reg + 8'h01;
                  byte_idx_reg <= 2'h0;
                end else begin
                  byte_idx_reg <= byte_idx_reg + 2'h1;
                end
              end
              default: begin
                sda_low_reg <= 1'b0;
              end
            endcase
          end
        end
      end
    end
  end

  // register store, written one whole register at a time
  always_ff @(posedge core_clk_i) begin
    if (ce_i && wr_complete) begin
      mem[sub_reg] <= commit_word;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_rd_data_o <= 32'h00000000;
      commit_o       <= 1'b0;
      commit_addr_o  <= 8'h00;
      commit_data_o  <= 32'h00000000;
    end else if (ce_i) begin
      core_rd_data_o <= mem[core_rd_addr_i];
      commit_o       <= wr_complete;
      if (wr_complete) begin
        commit_addr_o <= sub_reg;
        commit_data_o <= commit_word;
      end
    end
  end

endmodule
`default_nettype wire

/* pkg/i2c_link_pkg.sv */
// constants, encodings and state types shared by both ends of the two-wire link
// assumes a single 125 MHz core clock on each end
package i2c_link_pkg;

  localparam int CLK_HZ      = 125_000_000;
  localparam int SCL_STD_HZ  = 100_000;
  localparam int SCL_FAST_HZ = 400_000;
  // quarter bit period, least time so rounded up
  localparam int QTR_STD     = (CLK_HZ + 4 * SCL_STD_HZ - 1) / (4 * SCL_STD_HZ);
  localparam int QTR_FAST    = (CLK_HZ + 4 * SCL_FAST_HZ - 1) / (4 * SCL_FAST_HZ);
  localparam logic [8:0] QTR_STD_CYC  = 9'(QTR_STD);
  localparam logic [8:0] QTR_FAST_CYC = 9'(QTR_FAST);

  // slave addresses selected by the strap
  localparam logic [6:0] ADDR_STRAP_LOW  = 7'h1A;
  localparam logic [6:0] ADDR_STRAP_HIGH = 7'h1B;

  // subaddress map
  localparam logic [7:0]  SUB_WORD_BASE = 8'h20;
  localparam logic [7:0]  SUB_KEY       = 8'hF8;
  localparam logic [7:0]  SUB_NEW_ADDR  = 8'hF9;
  localparam logic [31:0] KEY_VALUE     = 32'hF9A5A5A5;
  localparam logic [1:0]  LAST_BYTE_IDX = 2'h3;
  localparam logic [3:0]  ACK_BIT       = 4'h8;
  localparam logic [3:0]  LAST_DATA_BIT = 4'h7;

  // host controller registers (byte addresses)
  localparam logic [11:0] REG_CMD    = 12'h000;
  localparam logic [11:0] REG_TXDATA = 12'h004;
  localparam logic [11:0] REG_STATUS = 12'h008;
  localparam logic [11:0] REG_CONFIG = 12'h00C;
  // command fields
  localparam int CMD_START = 0;
  localparam int CMD_BYTE  = 1;
  localparam int CMD_READ  = 2;
  localparam int CMD_NACK  = 3;
  localparam int CMD_STOP  = 4;
  // status fields
  localparam int STS_BUSY   = 0;
  localparam int STS_ACK    = 1;
  localparam int STS_RX_LSB = 8;
  // config fields
  localparam int CFG_FAST = 0;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ADDR   = 3'b001,
    ST_SUB    = 3'b010,
    ST_WR     = 3'b011,
    ST_RD     = 3'b100,
    ST_IGNORE = 3'b101
  } dev_state_e;

  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_START = 2'b01,
    H_BYTE  = 2'b10,
    H_STOP  = 2'b11
  } host_state_e;

endpackage

/* pkg/i2c_link_if.sv */
// open-drain two-wire link between the bus host and the register slave
// resolves the wired-AND level from the enables; a released line reads high
`timescale 1ns/1ps
`default_nettype none
interface i2c_link_if;
  logic host_scl_o;
  logic host_scl_oen;
  logic host_sda_o;
  logic host_sda_oen;
  logic dev_sda_o;
  logic dev_sda_oen;
  logic scl;
  logic sda;

  assign scl = host_scl_oen ? 1'b1 : host_scl_o;
  assign sda = (host_sda_oen ? 1'b1 : host_sda_o) & (dev_sda_oen ? 1'b1 : dev_sda_o);

  modport device (input scl, input sda, output dev_sda_o, output dev_sda_oen);
  modport host   (input scl, input sda, output host_scl_o, output host_scl_oen,
                  output host_sda_o, output host_sda_oen);
endinterface
`default_nettype wire

/* rtl/i2c_bus_host.sv */
// bus host end of the two-wire link, commanded by software over APB
// assumes the link is released high at reset and that no other master exists
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_host (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  i2c_link_if.host         link
);

  i2c_link_pkg::host_state_e state_reg;
  logic       sda_meta_reg;
  logic       sda_sync_reg;
  logic [8:0] q_cnt_reg;
  logic [1:0] qtr_reg;
  logic [3:0] bit_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic       fast_reg;
  logic       ack_rx_reg;
  logic       scl_low_reg;
  logic       sda_low_reg;
  logic       do_byte_reg;
  logic       do_read_reg;
  logic       do_nack_reg;
  logic       do_stop_reg;

  wire setup   = psel_i & ~penable_i;
  wire wr_acc  = psel_i & penable_i & pwrite_i;
  wire sel_cmd = (paddr_i == i2c_link_pkg::REG_CMD);
  wire sel_tx  = (paddr_i == i2c_link_pkg::REG_TXDATA);
  wire sel_sts = (paddr_i == i2c_link_pkg::REG_STATUS);
  wire sel_cfg = (paddr_i == i2c_link_pkg::REG_CONFIG);
  wire mapped  = sel_cmd | sel_tx | sel_sts | sel_cfg;
  wire busy    = (state_reg != i2c_link_pkg::H_IDLE);
  wire cmd_go  = wr_acc & sel_cmd & ~busy;

  wire [8:0] qtr_len = fast_reg ? i2c_link_pkg::QTR_FAST_CYC : i2c_link_pkg::QTR_STD_CYC;
  wire       tick    = (q_cnt_reg == qtr_len - 9'h001);
  wire       at_ack  = (bit_reg == i2c_link_pkg::ACK_BIT);
  wire [31:0] status = {16'h0000, shift_reg, 6'h00, ack_rx_reg, busy};
  wire [31:0] rd_mux = sel_sts ? status :
                       sel_tx  ? {24'h000000, tx_reg} :
                       sel_cfg ? {31'h00000000, fast_reg} : 32'h00000000;
  wire i2c_link_pkg::host_state_e after_byte = do_stop_reg ? i2c_link_pkg::H_STOP : i2c_link_pkg::H_IDLE;

  assign pready_o          = 1'b1;
  assign pslverr_o         = psel_i & penable_i & ~mapped;
  assign link.host_scl_o   = 1'b0;
  assign link.host_sda_o   = 1'b0;
  assign link.host_scl_oen = ~scl_low_reg;
  assign link.host_sda_oen = ~sda_low_reg;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o     <= 32'h00000000;
      tx_reg       <= 8'h00;
      fast_reg     <= 1'b0;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
    end else if (ce_i) begin
      sda_meta_reg <= link.sda;
      sda_sync_reg <= sda_meta_reg;
      if (setup) begin
        prdata_o <= rd_mux;
      end
      if (wr_acc && sel_tx) begin
        tx_reg <= pwdata_i[7:0];
      end
      if (wr_acc && sel_cfg) begin
        fast_reg <= pwdata_i[i2c_link_pkg::CFG_FAST];
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg   <= i2c_link_pkg::H_IDLE;
      q_cnt_reg   <= 9'h000;
      qtr_reg     <= 2'h0;
      bit_reg     <= 4'h0;
      shift_reg   <= 8'h00;
      ack_rx_reg  <= 1'b0;
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      do_byte_reg <= 1'b0;
      do_read_reg <= 1'b0;
      do_nack_reg <= 1'b0;
      do_stop_reg <= 1'b0;
    end else if (ce_i) begin
      if (cmd_go) begin
        do_byte_reg <= pwdata_i[i2c_link_pkg::CMD_BYTE];
        do_read_reg <= pwdata_i[i2c_link_pkg::CMD_READ];
        do_nack_reg <= pwdata_i[i2c_link_pkg::CMD_NACK];
        do_stop_reg <= pwdata_i[i2c_link_pkg::CMD_STOP];
        shift_reg   <= tx_reg;
        q_cnt_reg   <= 9'h000;
        qtr_reg     <= 2'h0;
        bit_reg     <= 4'h0;
        state_reg   <= pwdata_i[i2c_link_pkg::CMD_START] ? i2c_link_pkg::H_START :
                       pwdata_i[i2c_link_pkg::CMD_BYTE]  ? i2c_link_pkg::H_BYTE  :
                       pwdata_i[i2c_link_pkg::CMD_STOP]  ? i2c_link_pkg::H_STOP  : i2c_link_pkg::H_IDLE;
      end else if (busy) begin
        q_cnt_reg <= tick ? 9'h000 : q_cnt_reg + 9'h001;
        if (tick) begin
          qtr_reg <= qtr_reg + 2'h1;
          case (state_reg)
            i2c_link_pkg::H_START: begin
              // data falls while clock is high
              case (qtr_reg)
                2'h0:    sda_low_reg <= 1'b0;
                2'h1:    scl_low_reg <= 1'b0;
                2'h2:    sda_low_reg <= 1'b1;
                default: begin
                  scl_low_reg <= 1'b1;
                  state_reg   <= do_byte_reg ? i2c_link_pkg::H_BYTE : after_byte;
                end
              endcase
            end
            i2c_link_pkg::H_BYTE: begin
              case (qtr_reg)
                2'h0: begin
                  if (at_ack) begin
                    sda_low_reg <= do_read_reg & ~do_nack_reg;
                  end else begin
                    sda_low_reg <= ~do_read_reg & ~shift_reg[7];
                  end
                end
                2'h1:    scl_low_reg <= 1'b0;
                2'h2:    scl_low_reg <= 1'b0;
                default: begin
                  scl_low_reg <= 1'b1;
                  bit_reg     <= bit_reg + 4'h1;
                  if (at_ack) begin
                    ack_rx_reg <= ~sda_sync_reg;
                    state_reg  <= after_byte;
                  end else begin
                    shift_reg <= {shift_reg[6:0], sda_sync_reg};
                  end
                end
              endcase
            end
            i2c_link_pkg::H_STOP: begin
              // data rises while clock is high
              case (qtr_reg)
                2'h0:    sda_low_reg <= 1'b1;
                2'h1:    scl_low_reg <= 1'b0;
                2'h2:    sda_low_reg <= 1'b0;
                default: state_reg   <= i2c_link_pkg::H_IDLE;
              endcase
            end
            default: state_reg <= i2c_link_pkg::H_IDLE;
          endcase
        end
      end
    end
  end

endmodule
`default_nettype wire

/* tb/i2c_link_checker.sv */
// assertions on the shared two-wire link signals
// assumes one core clock domain, reset active low
`timescale 1ns/1ps
`default_nettype none
module i2c_link_checker (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_scl_o,
  input wire logic host_scl_oen,
  input wire logic host_sda_o,
  input wire logic host_sda_oen,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oen
);
  logic       scl_q;
  logic       sda_q;
  logic [3:0] bit_cnt;
  logic       first_byte;
  wire        start_ev = scl && scl_q && sda_q && !sda;
  wire        stop_ev  = scl && scl_q && !sda_q && sda;
  wire        scl_rise = scl && !scl_q;
  wire        scl_fall = !scl && scl_q;

  // bit position within the current byte, 9 is the acknowledge clock
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      bit_cnt    <= 4'h0;
      first_byte <= 1'b0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start_ev) begin
        bit_cnt    <= 4'h0;
        first_byte <= 1'b1;
      end else if (scl_rise) begin
        bit_cnt <= (bit_cnt == 4'h9) ? 4'h1 : bit_cnt + 4'h1;
      end else if (scl_fall && bit_cnt == 4'h9) begin
        first_byte <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_DEV_OPEN_DRAIN: assert property (!dev_sda_o) else $error("device drove sda high");
  AST_HOST_OPEN_DRAIN: assert property (!host_scl_o && !host_sda_o) else $error("host drove high");
  AST_NO_STRETCH: assert property (host_scl_oen |-> ##[0:1] scl) else $error("scl held low");
  AST_DEV_EDGE_LOW: assert property ($changed(dev_sda_oen) |-> !scl && !scl_q) else $error("sda moved in high");
  AST_ACK_WHOLE: assert property (scl && !dev_sda_oen |=> !dev_sda_oen || !scl) else $error("ack let go");
  AST_ADDR_FREE: assert property (scl && scl_q && first_byte && bit_cnt inside {[4'h1:4'h8]} |-> dev_sda_oen)
    else $error("device drove address bit");
  AST_RESET_FREE: assert property ($rose(rst_n_i) |-> dev_sda_oen && host_sda_oen && host_scl_oen)
    else $error("line held at reset exit");
  AST_START_FREE: assert property (start_ev |-> dev_sda_oen ##1 dev_sda_oen) else $error("device held start");

  COV_START: cover property (start_ev);
  COV_ACK: cover property (scl && scl_q && bit_cnt == 4'h9 && !dev_sda_oen);
  COV_STOP: cover property (stop_ev);
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench: APB-driven link host talking to the register slave
// assumes both ends join through the link interface, fast rate used
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk;
  logic        rst_n;
  logic        ce;
  logic        addr_sel;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        perr;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  core_rd_addr;
  logic [31:0] rdat;
  logic        com;
  logic [7:0]  com_a;
  logic [31:0] com_d;
  logic [6:0]  sa;
  logic [31:0] rd;
  logic [31:0] st;
  logic [31:0] w;
  logic [7:0]  sub;
  logic [7:0]  d;
  int          fail_count = 0;
  int          checks_done = 0;
  int          ncom = 0;

  i2c_link_if i2c_link_if_i ();
  i2c_register_access_slave i2c_register_access_slave_i (.core_clk_i(clk), .rst_n_i(rst_n), .ce_i(ce),
    .addr_sel_i(addr_sel), .core_rd_addr_i(core_rd_addr), .link(i2c_link_if_i), .core_rd_data_o(rdat),
    .commit_o(com), .commit_addr_o(com_a), .commit_data_o(com_d), .slave_addr_o(sa));
  i2c_bus_host i2c_bus_host_i (.core_clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .link(i2c_link_if_i));
  i2c_link_checker i2c_link_checker_i (.core_clk_i(clk), .rst_n_i(rst_n), .scl(i2c_link_if_i.scl),
    .sda(i2c_link_if_i.sda), .host_scl_o(i2c_link_if_i.host_scl_o), .host_scl_oen(i2c_link_if_i.host_scl_oen),
    .host_sda_o(i2c_link_if_i.host_sda_o), .host_sda_oen(i2c_link_if_i.host_sda_oen),
    .dev_sda_o(i2c_link_if_i.dev_sda_o), .dev_sda_oen(i2c_link_if_i.dev_sda_oen));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    if (com === 1'b1) ncom++;
  end

  function automatic logic [31:0] low_reg(input logic [7:0] b);
    return {24'h0, b};
  endfunction

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic run_cmd(input logic [31:0] c);
    apb(1'b1, i2c_link_pkg::REG_CMD, c);
    repeat (2) @(posedge clk);
    st = 32'h1;
    while (st[i2c_link_pkg::STS_BUSY] !== 1'b0) begin
      apb(1'b0, i2c_link_pkg::REG_STATUS, 32'h0);
      st = rd;
    end
  endtask

  task automatic xfer(input logic [7:0] q[$], input logic stp, input logic ea);
    logic [31:0] c;
    foreach (q[k]) begin
      c = 32'h0;
      c[i2c_link_pkg::CMD_START] = (k == 0);
      c[i2c_link_pkg::CMD_BYTE] = 1'b1;
      c[i2c_link_pkg::CMD_STOP] = stp && (k == q.size() - 1);
      apb(1'b1, i2c_link_pkg::REG_TXDATA, {24'h0, q[k]});
      run_cmd(c);
      check("ack", {31'h0, st[i2c_link_pkg::STS_ACK]}, {31'h0, ea});
    end
  endtask

  task automatic rd_byte(input logic last);
    logic [31:0] c;
    c = 32'h0;
    c[i2c_link_pkg::CMD_BYTE] = 1'b1;
    c[i2c_link_pkg::CMD_READ] = 1'b1;
    c[i2c_link_pkg::CMD_NACK] = last;
    c[i2c_link_pkg::CMD_STOP] = last;
    run_cmd(c);
  endtask

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    addr_sel = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    core_rd_addr = 8'h00;
    void'($urandom(32'h49EA));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    check("strap", {25'h0, sa}, {25'h0, i2c_link_pkg::ADDR_STRAP_LOW});
    apb(1'b1, 12'h010, 32'hFFFFFFFF);
    check("slverr", {31'h0, perr}, 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    check("unmapped", rd, 32'h0);
    apb(1'b1, i2c_link_pkg::REG_CONFIG, 32'h1);
    $display("test setup done");
    sub = 8'($urandom % 32);
    d = 8'($urandom);
    xfer({8'h34, sub, d}, 1'b1, 1'b1);
    check("commits", ncom, 32'h1);
    check("caddr", {24'h0, com_a}, {24'h0, sub});
    check("cdata", com_d, low_reg(d));
    core_rd_addr <= sub;
    repeat (2) @(posedge clk);
    check("store", rdat, low_reg(d));
    $display("test low write done");
    w = $urandom;
    xfer({8'h34, 8'h20, w[31:24], w[23:16], w[15:8], w[7:0], 8'h5A, 8'hC3}, 1'b1, 1'b1);
    check("commits", ncom, 32'h2);
    check("caddr", {24'h0, com_a}, 32'h20);
    check("cdata", com_d, w);
    $display("test word write done");
    xfer({8'h34, 8'h20}, 1'b0, 1'b1);
    xfer({8'h35}, 1'b0, 1'b1);
    for (int k = 0; k < 4; k++) begin
      rd_byte(k == 3);
      check("rx", {24'h0, st[i2c_link_pkg::STS_RX_LSB +: 8]}, {24'h0, w[31 - 8 * k -: 8]});
    end
    $display("test read done");
    xfer({8'h40}, 1'b1, 1'b0);
    check("commits", ncom, 32'h2);
    xfer({8'h34, 8'hF8, 8'hF9, 8'hA5, 8'hA5, 8'hA5, 8'h00, 8'h00, 8'h00, 8'h40}, 1'b1, 1'b1);
    check("newaddr", {25'h0, sa}, 32'h20);
    xfer({8'h40}, 1'b1, 1'b1);
    $display("test address change done");
    addr_sel <= 1'b1;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    check("strap", {25'h0, sa}, {25'h0, i2c_link_pkg::ADDR_STRAP_HIGH});
    $display("test strap done");
    stop_test();
  end

  initial begin
    // about 30 fast-rate bytes of 2844 cycles each, plus starts, stops and polling
    repeat (100000) @(posedge clk);
    fail_count++;
    $display("Error watchdog expected done seen hang");
    stop_test();
  end
endmodule
`default_nettype wire
